/* File: ccpt_defs.svh */
// register map, field positions, reset values and sizes for the capture/compare timer
`ifndef CCPT_DEFS_SVH
`define CCPT_DEFS_SVH
`define CCPT_ADDR_W 8
`define CCPT_OFS_CTRL 8'h00
`define CCPT_OFS_RELOAD 8'h04
`define CCPT_OFS_TIMER 8'h08
`define CCPT_OFS_CMP_A 8'h0C
`define CCPT_OFS_CMP_B 8'h10
`define CCPT_OFS_CMP_C 8'h14
`define CCPT_OFS_CMP_D 8'h18
`define CCPT_OFS_CAP_A 8'h1C
`define CCPT_OFS_CAP_B 8'h20
`define CCPT_OFS_CAPCFG 8'h24
`define CCPT_OFS_FLAGS 8'h28
`define CCPT_OFS_IEN 8'h2C
`define CCPT_OFS_OUTCFG 8'h30
`define CCPT_CTRL_RUN 0
`define CCPT_CTRL_DOWN 1
`define CCPT_CTRL_MODE_LO 2
`define CCPT_CTRL_MODE_HI 3
`define CCPT_CTRL_BYTE 4
`define CCPT_FLAG_OVF 0
`define CCPT_FLAG_CMP_LO 1
`define CCPT_FLAG_CAP_LO 5
`define CCPT_NFLAGS 7
`define CCPT_NCMP 4
`define CCPT_NCAP 2
`define CCPT_FILT_LEN 4
`define CCPT_RESP_OKAY 2'h0
`define CCPT_RESP_SLVERR 2'h2
`define CCPT_RELOAD_RST 16'hFFFF
`endif

/* File: ccpt_pkg.sv */
// types for the capture/compare timer
package ccpt_pkg;
  typedef enum logic [1:0] {CCPT_BASIC, CCPT_ASYM, CCPT_SYM, CCPT_RSVD} ccpt_mode_t;
  typedef enum logic {CCPT_RD_IDLE, CCPT_RD_RESP} ccpt_rd_t;
endpackage : ccpt_pkg

/* File: ccpt_timer.sv */
// capture/compare/pwm timer with an axi4-lite register slave
`timescale 1ns/10ps
`include "ccpt_defs.svh"

// Notes on behaviour
// - every reload sets the overflow flag, and an enabled flag requests an interrupt.
// - the timer can also run as an 8-bit timer counting up or down.
// - four compare channels act only when enabled, and the pin must be set to output.
// - a timer match with a channel's compare value sets that channel's match flag.
// - capture is always on, copying the timer into a 16-bit register per event.
// - each capture input selects rising or falling edge as its event.
// - with the filter on, an edge counts only after four equal samples.
// - a programmable event count holds back a capture until that many events pass.
// - asymmetrical pwm counts down whatever the direction bit says.
// - symmetrical pwm counts up and down alternately and compare drives the waveform.
// - connecting a compare pin keeps its current level unchanged.
// - the force-output bit holds the halt value; compare events, and the reload in asymmetrical pwm, change the pin.
module ccpt_timer
  import ccpt_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [1:0] I_CAP_IN,
  output logic [3:0] O_CMP_OUT,
  output logic [3:0] O_CMP_OE,
  output logic O_IRQ
);
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // registers
  logic [4:0] ctrl_q;
  logic [15:0] reload_q;
  logic [15:0] timer_q;
  logic [15:0] cmp_q [`CCPT_NCMP];
  logic [15:0] cap_q [`CCPT_NCAP];
  logic [11:0] capcfg_q;
  logic [`CCPT_NFLAGS-1:0] flags_q;
  logic [`CCPT_NFLAGS-1:0] ien_q;
  logic [11:0] outcfg_q;
  logic [15:0] timer_d;
  logic up_q;
  logic [`CCPT_NFLAGS-1:0] set_ev;
  logic [`CCPT_NFLAGS-1:0] clr_ev;

  // write channel: address and data taken in either order
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  assign O_AWREADY = !aw_have_q && !O_BVALID;
  assign O_WREADY = !w_have_q && !O_BVALID;
  assign wr_go = aw_have_q && w_have_q && !O_BVALID;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:2] <= `CCPT_OFS_OUTCFG >> 2);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction : merge

  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP <= `CCPT_RESP_OKAY;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_have_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= mapped(awaddr_q) ? `CCPT_RESP_OKAY : `CCPT_RESP_SLVERR;
      end
      else if (O_BVALID && I_BREADY)
        O_BVALID <= 1'b0;
    end
  end

  // configuration writes
  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q <= 5'h00;
      reload_q <= `CCPT_RELOAD_RST;
      for (int i = 0; i < `CCPT_NCMP; i++)
        cmp_q[i] <= 16'h0000;
      capcfg_q <= 12'h000;
      ien_q <= 7'h00;
      outcfg_q <= 12'h000;
    end
    else if (wr_go)
    begin
      if (hit(awaddr_q, `CCPT_OFS_CTRL))
        ctrl_q <= 5'(merge({27'h0, ctrl_q}, wdata_q, wstrb_q));
      if (hit(awaddr_q, `CCPT_OFS_RELOAD))
        reload_q <= 16'(merge({16'h0, reload_q}, wdata_q, wstrb_q));
      for (int i = 0; i < `CCPT_NCMP; i++)
        if (awaddr_q[7:2] == 6'(`CCPT_OFS_CMP_A / 4 + i))
          cmp_q[i] <= 16'(merge({16'h0, cmp_q[i]}, wdata_q, wstrb_q));
      if (hit(awaddr_q, `CCPT_OFS_CAPCFG))
        capcfg_q <= 12'(merge({20'h0, capcfg_q}, wdata_q, wstrb_q));
      if (hit(awaddr_q, `CCPT_OFS_IEN))
        ien_q <= 7'(merge({25'h0, ien_q}, wdata_q, wstrb_q));
      if (hit(awaddr_q, `CCPT_OFS_OUTCFG))
        outcfg_q <= 12'(merge({20'h0, outcfg_q}, wdata_q, wstrb_q));
    end
  end

  // write one to clear
  assign clr_ev = (wr_go && hit(awaddr_q, `CCPT_OFS_FLAGS) && wstrb_q[0]) ?
                  wdata_q[6:0] : 7'h00;

  // timer
  ccpt_mode_t mode;
  logic run;
  logic wrap;
  logic [15:0] top;
  assign mode = ccpt_mode_t'(ctrl_q[`CCPT_CTRL_MODE_HI:`CCPT_CTRL_MODE_LO]);
  assign run = ctrl_q[`CCPT_CTRL_RUN];
  assign top = ctrl_q[`CCPT_CTRL_BYTE] ? {8'h00, reload_q[7:0]} : reload_q;
  logic cnt_down;
  always_comb
  begin
    cnt_down = ctrl_q[`CCPT_CTRL_DOWN];
    if (mode == CCPT_ASYM)
      cnt_down = 1'b1;
    else if (mode == CCPT_SYM)
      cnt_down = !up_q;
  end

  always_comb
  begin
    wrap = 1'b0;
    timer_d = timer_q;
    if (run)
    begin
      if (mode == CCPT_SYM)
      begin
        if (up_q)
          timer_d = (timer_q >= top) ? timer_q - 16'h0001 : timer_q + 16'h0001;
        else if (timer_q == 16'h0000)
        begin
          timer_d = 16'h0001;
          wrap = 1'b1;
        end
        else
          timer_d = timer_q - 16'h0001;
      end
      else if (cnt_down)
      begin
        wrap = (timer_q == 16'h0000);
        timer_d = wrap ? top : timer_q - 16'h0001;
      end
      else
      begin
        wrap = (timer_q >= top);
        timer_d = wrap ? 16'h0000 : timer_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      timer_q <= 16'h0000;
      up_q <= 1'b1;
    end
    else
    begin
      timer_q <= timer_d;
      if (run && mode == CCPT_SYM)
      begin
        if (up_q && timer_q >= top)
          up_q <= 1'b0;
        else if (!up_q && timer_q == 16'h0000)
          up_q <= 1'b1;
      end
      else
        up_q <= 1'b1;
    end
  end

  // compare: outcfg = {fco[3:0], oe[3:0], en[3:0]}
  logic [3:0] match;
  always_comb
  begin
    for (int i = 0; i < `CCPT_NCMP; i++)
      match[i] = run && outcfg_q[i] && (timer_q == cmp_q[i]);
  end

  // pin holds its level when first connected; matches move it, and the asymmetrical pwm reload clears it
  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      O_CMP_OUT <= 4'h0;
    else
      for (int i = 0; i < `CCPT_NCMP; i++)
        if (!(outcfg_q[i] && outcfg_q[4+i]))
          O_CMP_OUT[i] <= outcfg_q[8+i];
        else if (match[i])
        begin
          // pwm: symmetrical sets on the up match and clears on the down match, asymmetrical sets on the match
          if (mode == CCPT_SYM)
            O_CMP_OUT[i] <= up_q;
          else if (mode == CCPT_ASYM)
            O_CMP_OUT[i] <= 1'b1;
          else
            O_CMP_OUT[i] <= !O_CMP_OUT[i];
        end
        else if (mode == CCPT_ASYM && wrap)
          O_CMP_OUT[i] <= 1'b0;
        else
          O_CMP_OUT[i] <= O_CMP_OUT[i];
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      O_CMP_OE <= 4'h0;
    else
      O_CMP_OE <= outcfg_q[7:4];
  end

  // capture: capcfg per input = {count[3:0], filter, edge}, input b at bits 11:6
  logic [1:0] cap_s1_q;
  logic [1:0] cap_s2_q;
  logic [`CCPT_FILT_LEN-1:0] hist_q [`CCPT_NCAP];
  logic [1:0] lvl_q;
  logic [3:0] evcnt_q [`CCPT_NCAP];
  logic [1:0] cap_ev;

  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cap_s1_q <= 2'b00;
      cap_s2_q <= 2'b00;
    end
    else
    begin
      cap_s1_q <= I_CAP_IN;
      cap_s2_q <= cap_s1_q;
    end
  end

  // filter costs three extra cycles of latency in exchange for glitch rejection
  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      lvl_q <= 2'b00;
      for (int c = 0; c < `CCPT_NCAP; c++)
      begin
        hist_q[c] <= '0;
        evcnt_q[c] <= 4'h0;
        cap_q[c] <= 16'h0000;
      end
    end
    else
      for (int c = 0; c < `CCPT_NCAP; c++)
      begin
        hist_q[c] <= {hist_q[c][`CCPT_FILT_LEN-2:0], cap_s2_q[c]};
        if (!capcfg_q[c*6+1])
          lvl_q[c] <= cap_s2_q[c];
        else if (&{hist_q[c][`CCPT_FILT_LEN-2:0], cap_s2_q[c]})
          lvl_q[c] <= 1'b1;
        else if (~|{hist_q[c][`CCPT_FILT_LEN-2:0], cap_s2_q[c]})
          lvl_q[c] <= 1'b0;
        if (cap_ev[c])
        begin
          if (evcnt_q[c] >= capcfg_q[c*6+2 +: 4])
          begin
            evcnt_q[c] <= 4'h0;
            cap_q[c] <= timer_q;
          end
          else
            evcnt_q[c] <= evcnt_q[c] + 4'h1;
        end
      end
  end

  logic [1:0] lvl_new;
  always_comb
  begin
    for (int c = 0; c < `CCPT_NCAP; c++)
    begin
      if (!capcfg_q[c*6+1])
        lvl_new[c] = cap_s2_q[c];
      else if (&{hist_q[c][`CCPT_FILT_LEN-2:0], cap_s2_q[c]})
        lvl_new[c] = 1'b1;
      else if (~|{hist_q[c][`CCPT_FILT_LEN-2:0], cap_s2_q[c]})
        lvl_new[c] = 1'b0;
      else
        lvl_new[c] = lvl_q[c];
      // edge select: 1 rising, 0 falling
      cap_ev[c] = (lvl_new[c] != lvl_q[c]) && (lvl_new[c] == capcfg_q[c*6]);
    end
  end

  logic [1:0] cap_done;
  always_comb
  begin
    for (int c = 0; c < `CCPT_NCAP; c++)
      cap_done[c] = cap_ev[c] && (evcnt_q[c] >= capcfg_q[c*6+2 +: 4]);
  end

  assign set_ev = {cap_done, match, wrap};

  // set wins over a clear in the same cycle
  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      flags_q <= 7'h00;
    else
      flags_q <= (flags_q & ~clr_ev) | set_ev;
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= |(((flags_q & ~clr_ev) | set_ev) & ien_q);
  end

  // read channel
  ccpt_rd_t rd_q;
  logic [31:0] rd_val;
  assign O_ARREADY = (rd_q == CCPT_RD_IDLE);
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (I_ARADDR[7:2])
      6'(`CCPT_OFS_CTRL >> 2): rd_val = {27'h0, ctrl_q};
      6'(`CCPT_OFS_RELOAD >> 2): rd_val = {16'h0, reload_q};
      6'(`CCPT_OFS_TIMER >> 2): rd_val = {16'h0, timer_q};
      6'(`CCPT_OFS_CMP_A >> 2): rd_val = {16'h0, cmp_q[0]};
      6'(`CCPT_OFS_CMP_B >> 2): rd_val = {16'h0, cmp_q[1]};
      6'(`CCPT_OFS_CMP_C >> 2): rd_val = {16'h0, cmp_q[2]};
      6'(`CCPT_OFS_CMP_D >> 2): rd_val = {16'h0, cmp_q[3]};
      6'(`CCPT_OFS_CAP_A >> 2): rd_val = {16'h0, cap_q[0]};
      6'(`CCPT_OFS_CAP_B >> 2): rd_val = {16'h0, cap_q[1]};
      6'(`CCPT_OFS_CAPCFG >> 2): rd_val = {20'h0, capcfg_q};
      6'(`CCPT_OFS_FLAGS >> 2): rd_val = {25'h0, flags_q};
      6'(`CCPT_OFS_IEN >> 2): rd_val = {25'h0, ien_q};
      6'(`CCPT_OFS_OUTCFG >> 2): rd_val = {20'h0, outcfg_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rd_q <= CCPT_RD_IDLE;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= `CCPT_RESP_OKAY;
    end
    else
      case (rd_q)
        CCPT_RD_IDLE:
          if (I_ARVALID)
          begin
            rd_q <= CCPT_RD_RESP;
            O_RDATA <= rd_val;
            O_RRESP <= mapped(I_ARADDR) ? `CCPT_RESP_OKAY : `CCPT_RESP_SLVERR;
          end
        CCPT_RD_RESP:
          if (I_RREADY)
            rd_q <= CCPT_RD_IDLE;
        default: rd_q <= CCPT_RD_IDLE;
      endcase
  end
  assign O_RVALID = (rd_q == CCPT_RD_RESP);
endmodule : ccpt_timer

/* File: ccpt_timer_chk.sv */
// port checker for the capture/compare timer, bound to its top
`timescale 1ns/10ps
module ccpt_timer_chk (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [3:0] O_CMP_OE,
  input wire logic O_IRQ
);
  default clocking dc @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_wr_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_wr_done;
    O_BVALID && I_BREADY;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##2 O_BVALID)
    else $error("no write response after address and data");
  a_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("no read data after address");
  a_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped before acceptance");
  a_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped before acceptance");
  a_b_release: assert property (s_wr_done |=> !O_BVALID)
    else $error("write response repeated");
  a_wr_refuse: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write accepted while response pending");
  a_rd_refuse: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read accepted while data pending");
  // pin enables only move by software, never on their own
  a_oe_by_write: assert property ($changed(O_CMP_OE) |-> O_BVALID || $past(O_BVALID))
    else $error("pin enable changed without a write");
  // flags only clear by software, so a request only falls after a write
  a_irq_fall: assert property ($fell(O_IRQ) |-> O_BVALID || $past(O_BVALID))
    else $error("request fell without a write");
endmodule : ccpt_timer_chk
bind ccpt_timer ccpt_timer_chk u_ccpt_timer_chk (.I_REF_CLK, .I_RST_N, .I_AWVALID, .O_AWREADY,
  .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RDATA,
  .O_RVALID, .I_RREADY, .O_CMP_OE, .O_IRQ);

/* File: ccpt_pins.sv */
// far-side pin model: capture sources and compare pin wires
`timescale 1ns/10ps
module ccpt_pins (
  input wire logic i_clk,
  input wire logic [1:0] i_lvl,
  input wire logic i_glitch,
  input wire logic [3:0] i_cmp_out,
  input wire logic [3:0] i_cmp_oe,
  output logic [1:0] o_cap,
  output logic [3:0] o_pin
);
  logic [1:0] glitch_q = 2'h0;
  // spike of two cycles, shorter than the filter window
  always @(posedge i_clk)
  begin
    glitch_q <= i_glitch ? 2'h2 : glitch_q - 2'(glitch_q != 2'h0);
  end
  assign o_cap = i_lvl ^ {2{glitch_q != 2'h0}};
  // an undriven pin floats to its pull-up
  assign o_pin = (i_cmp_out & i_cmp_oe) | ~i_cmp_oe;
endmodule : ccpt_pins

/* File: capture_compare_pwm_timer_tb.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/10ps
`include "ccpt_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t ns: got %0h expected %0h", $time, g, e); end end
module capture_compare_pwm_timer_tb;
  localparam logic [12:0] RW = 13'h1A7B;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic glitch = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq, pv;
  logic [1:0] bresp, rresp, cap, wrsp, rrsp;
  logic [31:0] rdata, rdat, t1;
  logic [3:0] cmp_out, cmp_oe, pin;
  logic [31:0] mdl [13];
  int mismatches = 0;
  int checks_done = 0;
  int top, nchg;

  ccpt_timer u_ccpt_timer (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr),
    .I_AWVALID(awv), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wv),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_CAP_IN(cap),
    .O_CMP_OUT(cmp_out), .O_CMP_OE(cmp_oe), .O_IRQ(irq));
  ccpt_pins u_ccpt_pins (.i_clk(clk), .i_lvl(lvl), .i_glitch(glitch), .i_cmp_out(cmp_out),
    .i_cmp_oe(cmp_oe), .o_cap(cap), .o_pin(pin));

  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // response ready is raised late on purpose so stalls get exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready) && n < 50);
    bready <= 1'b0;
    wrsp = bresp;
    // model keeps only the byte lanes that were strobed
    for (int b = 0; b < 4; b++)
      if (a <= `CCPT_OFS_OUTCFG && wstrb[b]) mdl[a[7:2]][b*8 +: 8] = d[b*8 +: 8];
    if (n >= 50)
    begin
      mismatches++;
      print_verdict();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready) arv <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 50);
    rready <= 1'b0;
    rdat = rdata;
    rrsp = rresp;
    if (n >= 50)
    begin
      mismatches++;
      print_verdict();
    end
  endtask : rd

  task automatic ck_all();
    for (int i = 0; i < 13; i++)
    begin
      if (RW[i])
      begin
        rd(8'(i * 4));
        `CHK(rdat, mdl[i])
      end
    end
  endtask : ck_all

  initial
  begin
    void'($urandom(82398));
    for (int i = 0; i < 13; i++) mdl[i] = 32'h0;
    mdl[1] = 32'(`CCPT_RELOAD_RST);
    cyc(4);
    rst_n <= 1'b1;
    cyc(3);
    ck_all();
    for (int i = 3; i < 7; i++) wr(8'(i * 4), $urandom & 32'h0000FFFF);
    // a single-lane write must leave the other byte alone
    wstrb <= 4'h2;
    wr(`CCPT_OFS_CMP_C, $urandom & 32'h0000FFFF);
    wstrb <= 4'hF;
    ck_all();
    rd(8'h40);
    `CHK({rrsp, rdat}, {`CCPT_RESP_SLVERR, 32'h0})
    wr(8'h34, 32'h1);
    `CHK(wrsp, `CCPT_RESP_SLVERR)
    // overflow flag holds and requests until cleared
    top = 4 + $urandom % 8;
    wr(`CCPT_OFS_RELOAD, 32'(top));
    wr(`CCPT_OFS_IEN, 32'h1);
    wr(`CCPT_OFS_CTRL, 32'h1);
    cyc(3 * top + 3);
    wr(`CCPT_OFS_CTRL, 32'h0);
    cyc(5);
    rd(`CCPT_OFS_FLAGS);
    `CHK(rdat[0], 1'b1)
    `CHK(irq, 1'b1)
    rd(`CCPT_OFS_TIMER);
    `CHK(rdat <= 32'(top), 1'b1)
    wr(`CCPT_OFS_FLAGS, 32'h7F);
    cyc(2);
    `CHK(irq, 1'b0)
    // byte timer counting down ignores the upper reload byte
    wr(`CCPT_OFS_RELOAD, 32'h1210);
    wr(`CCPT_OFS_CTRL, 32'h13);
    cyc(60);
    wr(`CCPT_OFS_CTRL, 32'h0);
    rd(`CCPT_OFS_TIMER);
    `CHK(rdat <= 32'h10, 1'b1)
    // only the enabled channel flags its match
    wr(`CCPT_OFS_RELOAD, 32'h14);
    wr(`CCPT_OFS_CMP_A, 32'h5);
    wr(`CCPT_OFS_CMP_B, 32'h6);
    wr(`CCPT_OFS_OUTCFG, 32'h1);
    wr(`CCPT_OFS_FLAGS, 32'h7F);
    wr(`CCPT_OFS_CTRL, 32'h1);
    cyc(50);
    wr(`CCPT_OFS_CTRL, 32'h0);
    rd(`CCPT_OFS_FLAGS);
    `CHK(rdat[4:1], 4'h1)
    // symmetrical waveform sets and clears the connected pin
    wr(`CCPT_OFS_OUTCFG, 32'h11);
    wr(`CCPT_OFS_CTRL, 32'h9);
    nchg = 0;
    pv = pin[0];
    for (int k = 0; k < 120; k++)
    begin
      @(posedge clk);
      if (pin[0] !== pv) nchg++;
      pv = pin[0];
    end
    `CHK(nchg >= 4, 1'b1)
    `CHK(cmp_oe[0], 1'b1)
    // asymmetrical mode counts down with the direction bit clear
    wr(`CCPT_OFS_CTRL, 32'h0);
    wr(`CCPT_OFS_RELOAD, 32'hFFFF);
    wr(`CCPT_OFS_CTRL, 32'h5);
    cyc(30);
    wr(`CCPT_OFS_CTRL, 32'h4);
    rd(`CCPT_OFS_TIMER);
    t1 = rdat;
    wr(`CCPT_OFS_CTRL, 32'h5);
    cyc(5);
    wr(`CCPT_OFS_CTRL, 32'h4);
    rd(`CCPT_OFS_TIMER);
    `CHK(rdat < t1, 1'b1)
    // halt value drives the pin, connecting keeps it
    for (int v = 0; v < 2; v++)
    begin
      wr(`CCPT_OFS_OUTCFG, 32'(v) << 8);
      cyc(3);
      `CHK(cmp_out[0], 1'(v))
      wr(`CCPT_OFS_OUTCFG, (32'(v) << 8) | 32'h11);
      cyc(8);
      `CHK(pin[0], 1'(v))
    end
    // capture on the selected edge of each input
    rd(`CCPT_OFS_TIMER);
    t1 = rdat;
    wr(`CCPT_OFS_CAPCFG, 32'h1);
    wr(`CCPT_OFS_FLAGS, 32'h7F);
    lvl <= 2'h3;
    cyc(6);
    rd(`CCPT_OFS_FLAGS);
    `CHK(rdat[6:5], 2'h1)
    rd(`CCPT_OFS_CAP_A);
    `CHK(rdat, t1)
    lvl <= 2'h0;
    cyc(6);
    rd(`CCPT_OFS_FLAGS);
    `CHK(rdat[6:5], 2'h3)
    rd(`CCPT_OFS_CAP_B);
    `CHK(rdat, t1)
    // filter rejects a short spike but takes a steady edge
    wr(`CCPT_OFS_FLAGS, 32'h7F);
    wr(`CCPT_OFS_CAPCFG, 32'h3);
    glitch <= 1'b1;
    @(posedge clk);
    glitch <= 1'b0;
    cyc(8);
    rd(`CCPT_OFS_FLAGS);
    `CHK(rdat[5], 1'b0)
    lvl <= 2'h1;
    cyc(10);
    rd(`CCPT_OFS_FLAGS);
    `CHK(rdat[5], 1'b1)
    // event count of two captures on the third edge
    lvl <= 2'h0;
    cyc(8);
    wr(`CCPT_OFS_FLAGS, 32'h7F);
    wr(`CCPT_OFS_CAPCFG, 32'h9);
    for (int k = 0; k < 3; k++)
    begin
      rd(`CCPT_OFS_FLAGS);
      `CHK(rdat[5], 1'b0)
      lvl <= 2'h1;
      cyc(5);
      lvl <= 2'h0;
      cyc(5);
    end
    rd(`CCPT_OFS_FLAGS);
    `CHK(rdat[5], 1'b1)
    print_verdict();
  end
endmodule : capture_compare_pwm_timer_tb
